// ==== hw/ubs_serial_engine.v ====
// ubs_serial_engine.v: byte serializer and deserializer, 8N1, fixed baud divider
// assumes i_rx already synchronised by the caller; one system clock
`include "ubs_defs.vh"

module ubs_serial_engine (
  input  wire        i_clock,
  input  wire        i_resetn,
  input  wire        i_tx_start,
  input  wire [7:0]  i_tx_byte,
  output reg         o_tx_done,
  output reg         o_tx_line,
  input  wire        i_rx,
  output reg         o_rx_valid,
  output reg  [7:0]  o_rx_byte
);

  localparam ST_IDLE = 1'b0;
  localparam ST_BUSY = 1'b1;

  reg        tx_state_r;
  reg [9:0]  tx_shift_r;
  reg [3:0]  tx_bits_r;
  reg [15:0] tx_div_r;

  always @(posedge i_clock) begin
    o_tx_done <= 1'b0;
    if (!i_resetn) begin
      tx_state_r <= ST_IDLE;
      tx_shift_r <= 10'h3FF;
      tx_bits_r  <= 4'h0;
      tx_div_r   <= `UBS_ZERO16;
      o_tx_line  <= 1'b1;
    end else begin
      case (tx_state_r)
        ST_IDLE: begin
          o_tx_line <= 1'b1;
          if (i_tx_start) begin
            tx_shift_r <= {1'b1, i_tx_byte, 1'b0};
            tx_bits_r  <= `UBS_FRAME_BITS;
            tx_div_r   <= `UBS_ZERO16;
            tx_state_r <= ST_BUSY;
          end
        end
        ST_BUSY: begin
          if (tx_div_r == `UBS_ZERO16) begin
            tx_div_r <= `UBS_BAUD_DIV;
            if (tx_bits_r == 4'h0) begin
              tx_state_r <= ST_IDLE;
              o_tx_done  <= 1'b1;
            end else begin
              o_tx_line  <= tx_shift_r[0];
              tx_shift_r <= {1'b1, tx_shift_r[9:1]};
              tx_bits_r  <= tx_bits_r - `UBS_ONE4;
            end
          end else begin
            tx_div_r <= tx_div_r - `UBS_ONE16;
          end
        end
        default: tx_state_r <= ST_IDLE;
      endcase
    end
  end

  reg        rx_state_r;
  reg [8:0]  rx_shift_r;
  reg [3:0]  rx_bits_r;
  reg [15:0] rx_div_r;

  always @(posedge i_clock) begin
    o_rx_valid <= 1'b0;
    if (!i_resetn) begin
      rx_state_r <= ST_IDLE;
      rx_shift_r <= 9'h000;
      rx_bits_r  <= 4'h0;
      rx_div_r   <= `UBS_ZERO16;
      o_rx_byte  <= `UBS_ZERO8;
    end else begin
      case (rx_state_r)
        ST_IDLE: begin
          if (!i_rx) begin
            rx_div_r   <= `UBS_BAUD_HALF;
            rx_bits_r  <= `UBS_FRAME_BITS;
            rx_state_r <= ST_BUSY;
          end
        end
        ST_BUSY: begin
          if (rx_div_r == `UBS_ZERO16) begin
            rx_div_r <= `UBS_BAUD_DIV;
            // sample mid-bit; start, 8 data, stop
            rx_shift_r <= {i_rx, rx_shift_r[8:1]};
            if (rx_bits_r == `UBS_ONE4) begin
              rx_state_r <= ST_IDLE;
              o_rx_valid <= i_rx;
              o_rx_byte  <= rx_shift_r[8:1];
            end
            rx_bits_r <= rx_bits_r - `UBS_ONE4;
          end else begin
            rx_div_r <= rx_div_r - `UBS_ONE16;
          end
        end
        default: rx_state_r <= ST_IDLE;
      endcase
    end
  end

endmodule // ubs_serial_engine

// ==== hw/ubs_uart_flags.v ====
// ubs_uart_flags.v: uart byte buffer, buffer status flags and interrupt logic
// assumes a single-cycle register port master on i_clock and an async rx pin
//
// Functional notes
// - status register is read only; writes never change the flags
// - status bit 1 reads 1 while a received byte waits unread
// - receive full may raise interrupt 5, gated by uart enable bit at 0xC00E
// - reading the byte buffer clears receive full automatically
// - byte buffer register decoded at 0xC0E4, readable and writable
// - status bit 0 set by byte buffer write, cleared when sending ends
// - transmit empty may raise interrupt 4, gated by the same enable bit
// - byte buffer write starts sending; data sits in bits 7 to 0
//
// Chosen here: the address-and-strobe port.
`include "ubs_defs.vh"

module ubs_uart_flags (
  input  wire        i_clock,
  input  wire        i_resetn,
  input  wire [15:0] i_addr,
  input  wire [15:0] i_wdata,
  input  wire        i_wr,
  input  wire        i_rd,
  output reg  [15:0] o_rdata,
  input  wire        i_rx_pin,
  output wire        o_tx_pin,
  output wire        o_cpu_irq4,
  output wire        o_cpu_irq5,
  output wire        o_irq
);

  reg        rx_meta_r;
  reg        rx_sync_r;
  reg        tx_full_r;
  reg        tx_full_nxt;
  reg        tx_start_r;
  reg        tx_start_nxt;
  reg [7:0]  tx_byte_r;
  reg [7:0]  tx_byte_nxt;
  reg        rx_full_r;
  reg        rx_full_nxt;
  reg [7:0]  rx_byte_r;
  reg [7:0]  rx_byte_nxt;
  reg        uart_en_r;
  reg        uart_en_nxt;
  reg [1:0]  irq_mask_r;
  reg [1:0]  irq_mask_nxt;
  reg [1:0]  irq_stat_r;
  wire [1:0] irq_stat_nxt;
  reg [15:0] rdata_nxt;
  reg        sel_buf;
  reg        sel_stat;
  reg        sel_en;
  reg        sel_evt;
  reg        sel_mask;
  wire       tx_done;
  wire       rx_valid;
  wire [7:0] rx_byte;
  wire [1:0] evt;

  // one select per mapped address; unmapped addresses select nothing
  always @* begin
    sel_buf  = 1'b0;
    sel_stat = 1'b0;
    sel_en   = 1'b0;
    sel_evt  = 1'b0;
    sel_mask = 1'b0;
    case (i_addr)
      `UBS_ADDR_BYTE_BUF: sel_buf  = 1'b1;
      `UBS_ADDR_STATUS:   sel_stat = 1'b1;
      `UBS_ADDR_IRQ_EN:   sel_en   = 1'b1;
      `UBS_ADDR_IRQ_STAT: sel_evt  = 1'b1;
      `UBS_ADDR_IRQ_MASK: sel_mask = 1'b1;
      default:            sel_buf  = 1'b0;
    endcase
  end

  wire wr_buf  = i_wr && sel_buf;
  wire rd_buf  = i_rd && sel_buf;
  wire wr_en   = i_wr && sel_en;
  wire wr_mask = i_wr && sel_mask;
  wire rd_stat = i_rd && sel_evt;

  always @(posedge i_clock) begin
    if (!i_resetn) begin
      rx_meta_r <= 1'b1;
      rx_sync_r <= 1'b1;
    end else begin
      rx_meta_r <= i_rx_pin;
      rx_sync_r <= rx_meta_r;
    end
  end

  ubs_serial_engine u_engine (
    .i_clock    (i_clock),
    .i_resetn   (i_resetn),
    .i_tx_start (tx_start_r),
    .i_tx_byte  (tx_byte_r),
    .o_tx_done  (tx_done),
    .o_tx_line  (o_tx_pin),
    .i_rx       (rx_sync_r),
    .o_rx_valid (rx_valid),
    .o_rx_byte  (rx_byte)
  );

  assign evt[`UBS_STAT_RX_EVT] = rx_valid;
  assign evt[`UBS_STAT_TX_EVT] = tx_done;

  // one sticky bit per event; a new event wins over the clearing read
  genvar gi;
  generate
    for (gi = 0; gi < `UBS_EVT_COUNT; gi = gi + 1) begin : g_sticky
      assign irq_stat_nxt[gi] = evt[gi] | (irq_stat_r[gi] & ~rd_stat);
    end
  endgenerate

  // transmit side: a write while still sending is dropped
  always @* begin
    tx_full_nxt  = tx_full_r;
    tx_start_nxt = 1'b0;
    tx_byte_nxt  = tx_byte_r;
    if (wr_buf && !tx_full_r) begin
      tx_full_nxt  = 1'b1;
      tx_start_nxt = 1'b1;
      tx_byte_nxt  = i_wdata[`UBS_BYTE_MSB:`UBS_BYTE_LSB];
    end else if (tx_done) begin
      tx_full_nxt = 1'b0;
    end
  end

  // receive side: a byte landing in the clearing cycle keeps the flag set
  always @* begin
    rx_full_nxt = rx_full_r;
    rx_byte_nxt = rx_byte_r;
    if (rx_valid) begin
      rx_full_nxt = 1'b1;
      rx_byte_nxt = rx_byte;
    end else if (rd_buf) begin
      rx_full_nxt = 1'b0;
    end
  end

  // control registers; the status address has no write path
  always @* begin
    uart_en_nxt  = uart_en_r;
    irq_mask_nxt = irq_mask_r;
    if (wr_en) begin
      uart_en_nxt = i_wdata[`UBS_BIT_UART_EN];
    end
    if (wr_mask) begin
      irq_mask_nxt = i_wdata[`UBS_MASK_MSB:`UBS_MASK_LSB];
    end
  end

  // read mux: every unmapped or reserved bit stays zero
  always @* begin
    rdata_nxt = `UBS_ZERO16;
    if (i_rd) begin
      if (sel_buf) begin
        rdata_nxt[`UBS_BYTE_MSB:`UBS_BYTE_LSB] = rx_byte_r;
      end
      if (sel_stat) begin
        rdata_nxt[`UBS_BIT_RX_FULL] = rx_full_r;
        rdata_nxt[`UBS_BIT_TX_FULL] = tx_full_r;
      end
      if (sel_en) begin
        rdata_nxt[`UBS_BIT_UART_EN] = uart_en_r;
      end
      if (sel_evt) begin
        rdata_nxt[`UBS_MASK_MSB:`UBS_MASK_LSB] = irq_stat_r;
      end
      if (sel_mask) begin
        rdata_nxt[`UBS_MASK_MSB:`UBS_MASK_LSB] = irq_mask_r;
      end
    end
  end

  always @(posedge i_clock) begin
    if (!i_resetn) begin
      tx_full_r  <= 1'b0;
      tx_start_r <= 1'b0;
      tx_byte_r  <= `UBS_ZERO8;
    end else begin
      tx_full_r  <= tx_full_nxt;
      tx_start_r <= tx_start_nxt;
      tx_byte_r  <= tx_byte_nxt;
    end
  end

  always @(posedge i_clock) begin
    if (!i_resetn) begin
      rx_full_r <= 1'b0;
      rx_byte_r <= `UBS_ZERO8;
    end else begin
      rx_full_r <= rx_full_nxt;
      rx_byte_r <= rx_byte_nxt;
    end
  end

  always @(posedge i_clock) begin
    if (!i_resetn) begin
      uart_en_r  <= 1'b0;
      irq_mask_r <= `UBS_ZERO2;
      irq_stat_r <= `UBS_ZERO2;
    end else begin
      uart_en_r  <= uart_en_nxt;
      irq_mask_r <= irq_mask_nxt;
      irq_stat_r <= irq_stat_nxt;
    end
  end

  // read data stand for exactly the cycle after the strobe
  always @(posedge i_clock) begin
    if (!i_resetn) begin
      o_rdata <= `UBS_ZERO16;
    end else begin
      o_rdata <= rdata_nxt;
    end
  end

  // cpu interrupt lines follow the flags, not the sticky events
  assign o_cpu_irq5 = uart_en_r && rx_full_r;
  assign o_cpu_irq4 = uart_en_r && !tx_full_r;
  assign o_irq      = |(irq_stat_r & irq_mask_r);

endmodule // ubs_uart_flags

// ==== inc/ubs_defs.vh ====
// ubs_defs.vh: addresses, bit positions and reset values of the uart buffer flag block
// assumes a 16-bit register word and a 100 MHz system clock
`ifndef UBS_DEFS_VH
`define UBS_DEFS_VH

`define UBS_ADDR_W          16
`define UBS_DATA_W          16
`define UBS_ADDR_BYTE_BUF   16'hC0E4
`define UBS_ADDR_STATUS     16'hC0E2
`define UBS_ADDR_IRQ_EN     16'hC00E
`define UBS_ADDR_IRQ_STAT   16'hC0E0
`define UBS_ADDR_IRQ_MASK   16'hC0DE
`define UBS_BIT_TX_FULL     0
`define UBS_BIT_RX_FULL     1
`define UBS_BIT_UART_EN     0
`define UBS_STAT_RX_EVT     1
`define UBS_STAT_TX_EVT     0
`define UBS_ZERO16          16'h0000
`define UBS_ZERO8           8'h00
`define UBS_BAUD_DIV        16'h0363
`define UBS_BAUD_HALF       16'h01B1
`define UBS_EVT_COUNT       2
`define UBS_BYTE_MSB        7
`define UBS_BYTE_LSB        0
`define UBS_MASK_MSB        1
`define UBS_MASK_LSB        0
`define UBS_ZERO2           2'h0
`define UBS_FRAME_BITS      4'hA
`define UBS_ONE16           16'h0001
`define UBS_ONE4            4'h1

`endif

// ==== test/testbench.sv ====
// testbench: registers, flags and serial traffic of the uart flag block
// assumes the serial peer on both pins
`include "ubs_defs.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic w; logic [15:0] a, d, e;} ubs_row_t;
  logic        i_clock = 1'b0;
  logic        i_resetn = 1'b0;
  logic [15:0] i_addr = 16'h0000;
  logic [15:0] i_wdata = 16'h0000;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  wire  [15:0] o_rdata;
  wire         rx_ln, tx_ln, irq4, irq5, irq;
  wire  [7:0]  got;
  int          got_n, fails, comparisons, n;
  logic [15:0] q;
  ubs_row_t    rows [5] = '{'{1'b1, `UBS_ADDR_STATUS, 16'hFFFF, 16'h0000},
    '{1'b1, 16'hC0E6, 16'h1234, 16'h0000}, '{1'b1, `UBS_ADDR_IRQ_MASK, 16'h0003, 16'h0003},
    '{1'b1, `UBS_ADDR_IRQ_EN, 16'h0001, 16'h0001}, '{1'b0, `UBS_ADDR_IRQ_STAT, 16'h0, 16'h0}};
  always #5 i_clock = ~i_clock;
  ubs_uart_flags i_dut (.i_clock(i_clock), .i_resetn(i_resetn), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_rx_pin(rx_ln),
    .o_tx_pin(tx_ln), .o_cpu_irq4(irq4), .o_cpu_irq5(irq5), .o_irq(irq));
  ubs_serial_peer i_peer (.i_clock(i_clock), .i_line_in(tx_ln), .o_line_out(rx_ln),
    .o_got_byte(got), .o_got_count(got_n));
  task automatic bus(input logic w, input logic [15:0] a, d);
    @(posedge i_clock);
    i_wr <= w;
    i_rd <= !w;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clock);
    i_wr <= 1'b0;
    i_rd <= 1'b0;
    #1 q = o_rdata;
  endtask
  task automatic chk(input logic [15:0] g, e);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic rdc(input logic [15:0] a, e);
    bus(1'b0, a, 16'h0000);
    chk(q, e);
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d, fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #300000;
    fails++;
    report_and_stop();
  end
  initial begin
    repeat (8) @(posedge i_clock);
    i_resetn <= 1'b1;
    chk({12'h000, tx_ln, irq4, irq5, irq}, 16'h0008);
    foreach (rows[i]) begin
      if (rows[i].w) bus(1'b1, rows[i].a, rows[i].d);
      rdc(rows[i].a, rows[i].e);
    end
    $display("register test done");
    bus(1'b1, `UBS_ADDR_BYTE_BUF, 16'h01A5);
    bus(1'b1, `UBS_ADDR_BYTE_BUF, 16'h003C);
    rdc(`UBS_ADDR_STATUS, 16'h0001);
    for (n = 0; n < 20000 && irq4 !== 1'b1; n++) @(posedge i_clock);
    chk({15'h0000, irq4}, 16'h0001);
    chk({8'h00, got}, 16'h00A5);
    chk(16'(got_n), 16'h0001);
    chk({15'h0000, irq}, 16'h0001);
    rdc(`UBS_ADDR_IRQ_STAT, 16'h0001);
    rdc(`UBS_ADDR_IRQ_STAT, 16'h0000);
    $display("transmit test done");
    bus(1'b1, `UBS_ADDR_IRQ_MASK, 16'h0000);
    i_peer.send_byte(8'h5A);
    for (n = 0; n < 2000 && irq5 !== 1'b1; n++) @(posedge i_clock);
    chk({15'h0000, irq}, 16'h0000);
    bus(1'b1, `UBS_ADDR_IRQ_MASK, 16'h0003);
    rdc(`UBS_ADDR_STATUS, 16'h0002);
    chk({14'h0000, irq5, irq}, 16'h0003);
    rdc(`UBS_ADDR_BYTE_BUF, 16'h005A);
    rdc(`UBS_ADDR_STATUS, 16'h0000);
    rdc(`UBS_ADDR_IRQ_STAT, 16'h0002);
    $display("receive test done");
    bus(1'b1, `UBS_ADDR_IRQ_EN, 16'h0000);
    chk({14'h0000, irq4, irq5}, 16'h0000);
    bus(1'b1, `UBS_ADDR_BYTE_BUF, 16'h0077);
    rdc(`UBS_ADDR_STATUS, 16'h0001);
    @(posedge i_clock);
    i_resetn <= 1'b0;
    repeat (2) @(posedge i_clock);
    i_resetn <= 1'b1;
    rdc(`UBS_ADDR_STATUS, 16'h0000);
    chk({12'h000, tx_ln, irq4, irq5, irq}, 16'h0008);
    $display("reset test done");
    report_and_stop();
  end
endmodule // testbench

// ==== test/ubs_serial_peer.sv ====
// serial peer: sends bytes on the receive pin, captures transmitted bytes
// assumes 8N1 at 868 clocks per bit, line idle high
module ubs_serial_peer (
  input  wire        i_clock,
  input  wire        i_line_in,
  output logic       o_line_out,
  output logic [7:0] o_got_byte,
  output int         o_got_count
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BIT_CYC = 868;
  initial begin
    o_line_out = 1'b1;
    o_got_byte = 8'h00;
    o_got_count = 0;
  end
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge i_clock);
      o_line_out <= f[i];
      repeat (BIT_CYC - 1) @(posedge i_clock);
    end
  endtask
  // sample each bit in its middle, lsb first
  always begin
    @(negedge i_line_in);
    repeat (BIT_CYC / 2) @(posedge i_clock);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(posedge i_clock);
      o_got_byte[i] = i_line_in;
    end
    repeat (BIT_CYC) @(posedge i_clock);
    o_got_count++;
  end
endmodule // ubs_serial_peer

// ==== test/ubs_uart_flags_asserts.sv ====
// checker for the uart flag block: bus, flag and interrupt timing
// assumes the enable bit only changes by bus writes
`include "ubs_defs.vh"
module ubs_uart_flags_asserts (
  input wire        i_clock,
  input wire        i_resetn,
  input wire [15:0] i_addr,
  input wire [15:0] i_wdata,
  input wire        i_wr,
  input wire        i_rd,
  input wire [15:0] o_rdata,
  input wire        o_tx_pin,
  input wire        o_cpu_irq4,
  input wire        o_cpu_irq5
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        en_r;
  logic [13:0] busy_n;
  // shadow of the enable bit and length of the current busy spell
  always @(posedge i_clock) begin
    if (!i_resetn) en_r <= 1'b0;
    else if (i_wr && i_addr == `UBS_ADDR_IRQ_EN) en_r <= i_wdata[0];
    if (!i_resetn || o_cpu_irq4 || !en_r) busy_n <= 14'h0000;
    else busy_n <= busy_n + 14'h0001;
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  sequence s_tx_wr;
    i_wr && i_addr == `UBS_ADDR_BYTE_BUF && o_cpu_irq4;
  endsequence
  chk_rdata_idle: assert property (!i_rd |=> o_rdata == 16'h0000)
    else $error("read data not zero outside a read");
  chk_status_zero: assert property (
    i_rd && i_addr == `UBS_ADDR_STATUS |=> o_rdata[15:2] == 14'h0000)
    else $error("reserved status bits not zero");
  chk_enable_gate: assert property (!en_r |-> !o_cpu_irq4 && !o_cpu_irq5)
    else $error("uart interrupt while disabled");
  chk_tx_set: assert property (s_tx_wr |=> !o_cpu_irq4)
    else $error("transmit full not set by write");
  chk_tx_start: assert property (s_tx_wr |-> ##[1:8] !o_tx_pin)
    else $error("no start bit after write");
  chk_tx_bound: assert property (busy_n < 14'h2260)
    else $error("transmit full held too long");
  chk_tx_len: assert property (
    $rose(o_cpu_irq4) && $past(en_r) |-> busy_n > 14'h2198)
    else $error("transmit full cleared too early");
  chk_rx_clear: assert property (
    i_rd && i_addr == `UBS_ADDR_BYTE_BUF && o_cpu_irq5 |=> !o_cpu_irq5)
    else $error("receive full not cleared by read");
endmodule // ubs_uart_flags_asserts
bind ubs_uart_flags ubs_uart_flags_asserts i_chk (.*);
